// [armgdm_pkg.sv]
/*
 Shared constants for the reference/microphone gain, alignment delay and
 output mux block: register map, field layout, reset values, mux codes.
 Assumes 32-bit AXI4-Lite register access and 16-bit signed audio samples.
*/
package armgdm_pkg;
	// ========================================================
	// Audio format and rates
	localparam int SAMPLE_W       = 16;
	localparam int MIC_COUNT      = 4;
	localparam int CLOCK_HZ       = 250_000_000;
	localparam int FRAME_RATE_HZ  = 48_000;
	localparam int MIC_RATE_HZ    = 16_000;
	localparam int FRAME_CYCLES   = CLOCK_HZ / FRAME_RATE_HZ;
	localparam int MIC_RATIO      = FRAME_RATE_HZ / MIC_RATE_HZ;
	localparam int GAIN_FRAC      = 12;
	localparam int POWER_SHIFT    = 8;

	// ========================================================
	// Register byte offsets
	localparam logic [7:0] REG_REF_GAIN  = 8'h00;
	localparam logic [7:0] REG_MIC_GAIN  = 8'h04;
	localparam logic [7:0] REG_LEFT_SEL  = 8'h08;
	localparam logic [7:0] REG_RIGHT_SEL = 8'h0c;
	localparam logic [7:0] REG_SILENCE   = 8'h10;
	localparam logic [7:0] REG_DELAY     = 8'h14;
	localparam logic [7:0] REG_UPSAMPLE  = 8'h18;
	localparam logic [7:0] REG_STATUS    = 8'h1c;
	localparam logic [7:0] REG_POWER     = 8'h20;

	// ========================================================
	// Field layout of the select registers
	localparam int SEL_CAT_LSB = 0;
	localparam int SEL_IDX_LSB = 8;

	// ========================================================
	// Mux category codes
	localparam logic [3:0] CAT_MIC_RAW   = 4'h1;
	localparam logic [3:0] CAT_MIC_POST  = 4'h3;
	localparam logic [3:0] CAT_REF_PRE   = 4'h4;
	localparam logic [3:0] CAT_REF_DELAY = 4'h5;
	localparam logic [3:0] CAT_REF_GAIN  = 4'hc;

	// ========================================================
	// Reset values and saturation limits
	localparam logic [15:0] GAIN_UNITY      = 16'h1000;
	localparam logic [11:0] LEFT_SEL_RESET  = 12'h004;
	localparam logic [11:0] RIGHT_SEL_RESET = 12'h00c;
	localparam logic [31:0] SILENCE_RESET   = 32'h0000000b;
	localparam logic [7:0]  DELAY_RESET     = 8'h00;
	localparam logic [1:0]  UPSAMPLE_RESET  = 2'h3;
	localparam logic [15:0] SAT_POS         = 16'h7fff;
	localparam logic [15:0] SAT_NEG         = 16'h8000;

	// ========================================================
	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [armgdm_top.sv]
/*
 Reference gain, common microphone gain, signed alignment delay, two-channel
 test output mux with per-output upsample hold, and reference power gate.
 Assumes synchronous sample inputs held between frames and an AXI4-Lite master.
*/
// What this block does
// RULE_01 - The reference is scaled by the reference gain after pre-processing, before processing.
// RULE_02 - The loudspeaker copy of the reference never sees the reference gain.
// RULE_03 - Category 4 index 0 picks pre-gain reference, category 12 index 0 post-gain reference.
// RULE_04 - After reset the reference gain is unity, so pre- and post-gain taps match.
// RULE_05 - One microphone gain value scales all four microphones alike.
// RULE_06 - Category 3 picks the post-gain post-delay microphone named by the index.
// RULE_07 - Category 5 index 0 picks the reference after gain and alignment delay.
// RULE_08 - Reference power below the silence threshold inhibits echo-canceller adaptation.
// RULE_09 - A positive delay setting delays only the reference by that many samples. The code caps it at DEPTH - 1 (63) samples.
// RULE_10 - A negative delay setting delays all microphones by its magnitude, reference undelayed. The code caps it at DEPTH - 1 (63) samples.
// RULE_11 - Microphones run at 16 kHz, so their taps need upsampling on a faster output.
// RULE_12 - Per-output upsample flags default set; cleared, the tap passes at the bus rate.
// RULE_13 - Gains saturate, and new settings take effect together on a sample boundary.
module armgdm_top import armgdm_pkg::*; #(
	parameter int FRAME_DIV = FRAME_CYCLES,
	parameter int DEPTH     = 64
) (
	// Clock and reset
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	// AXI4-Lite write
	input  wire logic [7:0]           s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	// AXI4-Lite read
	input  wire logic [7:0]           s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	// Audio inputs
	input  wire logic [SAMPLE_W-1:0]  ref_sample,
	input  wire logic [SAMPLE_W-1:0]  mic_sample_0,
	input  wire logic [SAMPLE_W-1:0]  mic_sample_1,
	input  wire logic [SAMPLE_W-1:0]  mic_sample_2,
	input  wire logic [SAMPLE_W-1:0]  mic_sample_3,
	// Loudspeaker copy and adaptation gate
	output logic [SAMPLE_W-1:0]       speaker_out,
	output logic                      adapt_enable,
	// Output frame stream
	output logic                      out_valid,
	input  wire logic                 out_ready,
	output logic [SAMPLE_W-1:0]       out_left,
	output logic [SAMPLE_W-1:0]       out_right
);
	import armgdm_pkg::*;

	localparam int PW = $clog2(DEPTH);
	localparam int DW = $clog2(FRAME_DIV);

	// ========================================================
	// Saturating Q4.12 gain
	function automatic logic [SAMPLE_W-1:0] gain_sat(input logic [SAMPLE_W-1:0] x,
		input logic [15:0] g);
		logic signed [32:0] prod;
		logic signed [32:0] shifted;
		prod    = $signed({{17{x[SAMPLE_W-1]}}, x}) * $signed({17'h00000, g});
		shifted = prod >>> GAIN_FRAC;
		if (shifted > $signed({{17{1'b0}}, SAT_POS}))
			gain_sat = SAT_POS;
		else if (shifted < $signed({{17{1'b1}}, SAT_NEG}))
			gain_sat = SAT_NEG;
		else
			gain_sat = shifted[SAMPLE_W-1:0];
	endfunction

	// ========================================================
	// Registers: shadow copies written by software, active copies used
	logic [15:0] ref_gain_reg, mic_gain_reg, ref_gain_act, mic_gain_act;
	logic [11:0] left_sel_reg, right_sel_reg, left_sel_act, right_sel_act;
	logic [31:0] silence_reg, silence_act, power;
	logic [7:0]  delay_reg, delay_act;
	logic [1:0]  upsample_reg, upsample_act;
	logic        overrun;

	// ========================================================
	// Frame and microphone rate enables
	logic [DW-1:0] div_cnt;
	logic [1:0]    phase;
	wire           frame_tick = (div_cnt == DW'(FRAME_DIV - 1));
	wire           mic_tick   = frame_tick && (phase == 2'h0); // RULE_11

	// Divider for the 48 kHz frame and the 16 kHz microphone phase
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div_cnt <= '0;
			phase   <= 2'h0;
		end else begin
			div_cnt <= frame_tick ? '0 : div_cnt + 1'b1;
			if (frame_tick)
				phase <= (phase == 2'(MIC_RATIO - 1)) ? 2'h0 : phase + 2'h1;
		end
	end

	// Settings switch together at the microphone sample boundary
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ref_gain_act  <= GAIN_UNITY;
			mic_gain_act  <= GAIN_UNITY;
			left_sel_act  <= LEFT_SEL_RESET;
			right_sel_act <= RIGHT_SEL_RESET;
			silence_act   <= SILENCE_RESET;
			delay_act     <= DELAY_RESET;
			upsample_act  <= UPSAMPLE_RESET;
		end else if (mic_tick) begin // RULE_13
			ref_gain_act  <= ref_gain_reg;
			mic_gain_act  <= mic_gain_reg;
			left_sel_act  <= left_sel_reg;
			right_sel_act <= right_sel_reg;
			silence_act   <= silence_reg;
			delay_act     <= delay_reg;
			upsample_act  <= upsample_reg;
		end
	end

	// ========================================================
	// Gain stages and alignment delay decode
	logic [SAMPLE_W-1:0] mic_raw    [MIC_COUNT];
	logic [SAMPLE_W-1:0] mic_gained [MIC_COUNT];
	logic [SAMPLE_W-1:0] mic_line   [MIC_COUNT][DEPTH];
	logic [SAMPLE_W-1:0] mic_del    [MIC_COUNT];
	logic [SAMPLE_W-1:0] tap_mic_raw[MIC_COUNT];
	logic [SAMPLE_W-1:0] tap_mic_del[MIC_COUNT];
	logic [SAMPLE_W-1:0] ref_line   [DEPTH];
	logic [SAMPLE_W-1:0] tap_ref_pre, tap_ref_gain, tap_ref_del;
	logic [PW-1:0]       wptr;

	assign mic_raw[0] = mic_sample_0;
	assign mic_raw[1] = mic_sample_1;
	assign mic_raw[2] = mic_sample_2;
	assign mic_raw[3] = mic_sample_3;

	wire                delay_neg  = delay_act[7];
	wire [7:0]          delay_abs  = delay_neg ? 8'h00 - delay_act : delay_act;
	wire [PW-1:0]       delay_mag  = (delay_abs > 8'(DEPTH - 1)) ? PW'(DEPTH - 1)
		: delay_abs[PW-1:0];
	wire [PW-1:0]       ref_d      = delay_neg ? '0 : delay_mag; // RULE_09
	wire [PW-1:0]       mic_d      = delay_neg ? delay_mag : '0; // RULE_10
	wire [SAMPLE_W-1:0] ref_gained = gain_sat(ref_sample, ref_gain_act); // RULE_01
	wire [SAMPLE_W-1:0] ref_del    = (ref_d == '0) ? ref_gained : ref_line[wptr - ref_d];

	// Per-microphone gain, delay line and taps
	generate
		for (genvar m = 0; m < MIC_COUNT; m++) begin : g_mic
			assign mic_gained[m] = gain_sat(mic_raw[m], mic_gain_act); // RULE_05
			assign mic_del[m]    = (mic_d == '0) ? mic_gained[m] : mic_line[m][wptr - mic_d];
			// Delay line write and tap capture
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					tap_mic_raw[m] <= '0;
					tap_mic_del[m] <= '0;
				end else if (mic_tick) begin
					mic_line[m][wptr] <= mic_gained[m];
					tap_mic_raw[m]    <= mic_raw[m];
					tap_mic_del[m]    <= mic_del[m]; // RULE_10
				end
			end
		end
	endgenerate

	// Reference delay line, taps and loudspeaker copy
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wptr         <= '0;
			tap_ref_pre  <= '0;
			tap_ref_gain <= '0;
			tap_ref_del  <= '0;
			speaker_out  <= '0;
		end else begin
			speaker_out <= ref_sample; // RULE_02
			if (mic_tick) begin
				ref_line[wptr] <= ref_gained;
				wptr           <= wptr + 1'b1;
				tap_ref_pre    <= ref_sample;
				tap_ref_gain   <= ref_gained; // RULE_04
				tap_ref_del    <= ref_del; // RULE_09
			end
		end
	end

	// ========================================================
	// Reference power estimate and adaptation gate
	wire signed [31:0] ref_sq  = $signed(tap_ref_gain) * $signed(tap_ref_gain);
	wire [31:0]        pw_next = power - (power >> POWER_SHIFT) + (ref_sq >> POWER_SHIFT);

	// Leaky average of squared post-gain reference
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			power        <= '0;
			adapt_enable <= 1'b0;
		end else begin
			if (mic_tick)
				power <= pw_next;
			adapt_enable <= (power >= silence_act); // RULE_08
		end
	end

	// ========================================================
	// Output mux
	function automatic logic [SAMPLE_W-1:0] pick(input logic [11:0] sel);
		logic [3:0] cat;
		logic [1:0] idx;
		logic       idx0;
		cat  = sel[SEL_CAT_LSB +: 4];
		idx  = sel[SEL_IDX_LSB +: 2];
		idx0 = (sel[SEL_IDX_LSB +: 4] == 4'h0);
		pick = '0;
		case (cat)
			CAT_MIC_RAW:   pick = tap_mic_raw[idx];
			CAT_MIC_POST:  pick = tap_mic_del[idx]; // RULE_06
			CAT_REF_PRE:   pick = idx0 ? tap_ref_pre : '0; // RULE_03
			CAT_REF_GAIN:  pick = idx0 ? tap_ref_gain : '0; // RULE_03
			CAT_REF_DELAY: pick = idx0 ? tap_ref_del : '0; // RULE_07
			default:       pick = '0;
		endcase
	endfunction

	logic [SAMPLE_W-1:0] left_hold, right_hold, left_pick, right_pick;

	// Procedural so the picks follow the taps read inside the function, not only the selects
	always_comb begin
		left_pick  = pick(left_sel_act);
		right_pick = pick(right_sel_act);
	end
	wire                 left_upd   = frame_tick && (!upsample_act[0] || mic_tick);
	wire                 right_upd  = frame_tick && (!upsample_act[1] || mic_tick);

	// Hold each 16 kHz pick for three frames when its upsample flag is set
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			left_hold  <= '0;
			right_hold <= '0;
		end else begin
			if (left_upd)
				left_hold <= left_pick; // RULE_12
			if (right_upd)
				right_hold <= right_pick; // RULE_12
		end
	end

	// ========================================================
	// Two-entry output buffer, pushed one clock cycle after each frame tick
	logic                       push_d, v1;
	logic [2*SAMPLE_W-1:0]      e1;
	wire                        pop     = out_valid && out_ready;
	wire                        push_ok = push_d && (!v1 || pop);
	wire [2*SAMPLE_W-1:0]       entry   = {left_hold, right_hold};

	// Shift buffer with head driving the output ports
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			push_d    <= 1'b0;
			out_valid <= 1'b0;
			v1        <= 1'b0;
			out_left  <= '0;
			out_right <= '0;
			e1        <= '0;
		end else begin
			push_d <= frame_tick;
			if (pop) begin
				out_valid              <= v1 || push_ok;
				{out_left, out_right}  <= v1 ? e1 : entry;
				v1                     <= v1 && push_ok;
				if (v1 && push_ok)
					e1 <= entry;
			end else if (push_ok) begin
				if (!out_valid) begin
					out_valid             <= 1'b1;
					{out_left, out_right} <= entry;
				end else begin
					v1 <= 1'b1;
					e1 <= entry;
				end
			end
		end
	end

	// ========================================================
	// AXI4-Lite slave
	logic        aw_full, w_full;
	logic [7:0]  aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	wire         do_write  = aw_full && w_full && !s_axi_bvalid;
	wire         ar_take   = s_axi_arvalid && s_axi_arready;
	wire         wr_mapped = (aw_addr <= REG_STATUS) && (aw_addr[1:0] == 2'h0);
	wire         st_clear  = do_write && (aw_addr == REG_STATUS) && w_strb[0] && w_data[1];
	wire         over_set  = push_d && !push_ok;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] s);
		for (int b = 0; b < 4; b++)
			merge[8*b +: 8] = s[b] ? d[8*b +: 8] : old[8*b +: 8];
	endfunction

	wire [31:0] m_ref  = merge({16'h0000, ref_gain_reg}, w_data, w_strb);
	wire [31:0] m_mic  = merge({16'h0000, mic_gain_reg}, w_data, w_strb);
	wire [31:0] m_lsel = merge({20'h00000, left_sel_reg}, w_data, w_strb);
	wire [31:0] m_rsel = merge({20'h00000, right_sel_reg}, w_data, w_strb);
	wire [31:0] m_sil  = merge(silence_reg, w_data, w_strb);
	wire [31:0] m_dly  = merge({24'h000000, delay_reg}, w_data, w_strb);
	wire [31:0] m_ups  = merge({30'h00000000, upsample_reg}, w_data, w_strb);

	// Write channel capture, register update and response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
			aw_full       <= 1'b0;
			w_full        <= 1'b0;
			aw_addr       <= '0;
			w_data        <= '0;
			w_strb        <= '0;
			ref_gain_reg  <= GAIN_UNITY;
			mic_gain_reg  <= GAIN_UNITY;
			left_sel_reg  <= LEFT_SEL_RESET;
			right_sel_reg <= RIGHT_SEL_RESET;
			silence_reg   <= SILENCE_RESET;
			delay_reg     <= DELAY_RESET;
			upsample_reg  <= UPSAMPLE_RESET;
			overrun       <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full       <= 1'b1;
				aw_addr       <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_full       <= 1'b1;
				w_data       <= s_axi_wdata;
				w_strb       <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (do_write) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
				case (aw_addr)
					REG_REF_GAIN:  ref_gain_reg  <= m_ref[15:0];
					REG_MIC_GAIN:  mic_gain_reg  <= m_mic[15:0];
					REG_LEFT_SEL:  left_sel_reg  <= m_lsel[11:0];
					REG_RIGHT_SEL: right_sel_reg <= m_rsel[11:0];
					REG_SILENCE:   silence_reg   <= m_sil;
					REG_DELAY:     delay_reg     <= m_dly[7:0];
					REG_UPSAMPLE:  upsample_reg  <= m_ups[1:0];
					default:       ;
				endcase
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				aw_full       <= 1'b0;
				w_full        <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
			// Overrun flag: a new overrun wins over a clear
			overrun <= over_set || (overrun && !st_clear);
		end
	end

	// Read data decode
	logic [31:0] rd_mux;
	logic        rd_ok;
	always_comb begin
		rd_ok  = 1'b1;
		rd_mux = '0;
		case (s_axi_araddr)
			REG_REF_GAIN:  rd_mux = {16'h0000, ref_gain_reg};
			REG_MIC_GAIN:  rd_mux = {16'h0000, mic_gain_reg};
			REG_LEFT_SEL:  rd_mux = {20'h00000, left_sel_reg};
			REG_RIGHT_SEL: rd_mux = {20'h00000, right_sel_reg};
			REG_SILENCE:   rd_mux = silence_reg;
			REG_DELAY:     rd_mux = {24'h000000, delay_reg};
			REG_UPSAMPLE:  rd_mux = {30'h00000000, upsample_reg};
			REG_STATUS:    rd_mux = {30'h00000000, overrun, adapt_enable};
			REG_POWER:     rd_mux = power;
			default:       rd_ok  = 1'b0;
		endcase
	end

	// Read channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= RESP_OKAY;
		end else if (ar_take) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rd_mux;
			s_axi_rresp   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// ========================================================
	// Assertions
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_unity_tick;
		(ref_gain_act == GAIN_UNITY) && mic_tick;
	endsequence
	property p_unity_ref;
		s_unity_tick |=> (tap_ref_gain == tap_ref_pre);
	endproperty
	a_unity_ref: assert property (p_unity_ref) else $error("unity gain changed ref"); // RULE_04
	property p_speaker;
		##1 (speaker_out == $past(ref_sample));
	endproperty
	a_speaker: assert property (p_speaker) else $error("speaker copy altered"); // RULE_02
	property p_pos_delay;
		(mic_tick && !delay_act[7]) |=> (tap_mic_del[0] == $past(mic_gained[0]));
	endproperty
	a_pos_delay: assert property (p_pos_delay) else $error("mic delayed on positive"); // RULE_09
	property p_neg_delay;
		(mic_tick && delay_act[7]) |=> (tap_ref_del == $past(ref_gained));
	endproperty
	a_neg_delay: assert property (p_neg_delay) else $error("ref delayed on negative"); // RULE_10
	property p_setting_boundary;
		!mic_tick |=> $stable(ref_gain_act) && $stable(left_sel_act) && $stable(delay_act);
	endproperty
	a_setting_boundary: assert property (p_setting_boundary) else $error("setting mid frame"); // RULE_13
	property p_hold;
		(frame_tick && !mic_tick && upsample_act[0]) |=> $stable(left_hold);
	endproperty
	a_hold: assert property (p_hold) else $error("upsampled tap changed"); // RULE_12
	property p_gate;
		##1 (adapt_enable == ($past(power) >= $past(silence_act)));
	endproperty
	a_gate: assert property (p_gate) else $error("adaptation gate wrong"); // RULE_08
	sequence s_pre_sel;
		frame_tick && !upsample_act[0] && (left_sel_act == {8'h00, CAT_REF_PRE});
	endsequence
	property p_pre_sel;
		s_pre_sel |=> (left_hold == $past(tap_ref_pre));
	endproperty
	a_pre_sel: assert property (p_pre_sel) else $error("pre-gain pick wrong"); // RULE_03
	property p_sat;
		(mic_tick && ref_sample == SAT_POS && ref_gain_act > GAIN_UNITY) |=>
			(tap_ref_gain == SAT_POS);
	endproperty
	a_sat: assert property (p_sat) else $error("gain wrapped"); // RULE_13
endmodule

// [armgdm_far_model.sv]
/*
 Far-side model: reference source, microphone array and output sink.
 Assumes the bench sets levels and stall just after rising edges.
*/
module armgdm_far_model (
	// Clock and reset
	input  wire logic             aclk,
	input  wire logic             aresetn,
	// Commands from the bench
	input  wire logic [15:0]      want_ref,
	input  wire logic [3:0][15:0] want_mic,
	input  wire logic             stall,
	// Pins toward the block
	output logic [15:0]           ref_sample,
	output logic [3:0][15:0]      mic_sample,
	output logic                  out_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	// Levels change only at edges; sink refuses during reset or stall
	always_ff @(posedge aclk) begin
		ref_sample <= want_ref;
		mic_sample <= want_mic;
		out_ready  <= aresetn & ~stall;
	end
endmodule

// [tb_audio_ref_mic_gain_delay_mux.sv]
/*
 Bench: register access, reference and microphone taps, alignment delay,
 adaptation gate and output buffer stall. Assumes armgdm_far_model.
*/
module tb_audio_ref_mic_gain_delay_mux;
	timeunit 1ns;
	timeprecision 1ps;
	import armgdm_pkg::*;
	// ========================================================
	// Setup
	localparam int DIV = 12;
	localparam logic [7:0]  DLY [5]   = '{8'h03, 8'h03, 8'hfd, 8'hfd, 8'h00};
	localparam logic [11:0] LS [5]    = '{12'h005, 12'h003, 12'h003, 12'h005, 12'h00c};
	localparam logic [11:0] RS [5]    = '{12'h00c, 12'h001, 12'h001, 12'h00c, 12'h00c};
	localparam bit          STEP [5]  = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
	localparam int          EXP_N [5] = '{3 * MIC_RATIO, 0, 3 * MIC_RATIO, 0, MIC_RATIO - 1};
	logic             aclk = 1'b0;
	logic             aresetn = 1'b0;
	logic [7:0]       awaddr = 8'h00;
	logic [7:0]       araddr = 8'h00;
	logic             awvalid = 1'b0;
	logic             wvalid = 1'b0;
	logic             bready = 1'b0;
	logic             arvalid = 1'b0;
	logic             rready = 1'b0;
	logic             stall = 1'b0;
	logic [31:0]      wdata = 32'h0;
	logic [15:0]      want_ref = 16'h0;
	logic [3:0][15:0] want_mic = '0;
	logic [3:0][15:0] mic_s;
	logic [15:0]      ref_s, spk, oleft, oright, fl, fr;
	logic             awready, wready, bvalid, arready, rvalid, adapt, ovalid, ordy;
	logic [1:0]       bresp, rresp, resp;
	logic [31:0]      rdata, rdv;
	int               error_cnt = 0;
	int               check_count = 0;

	armgdm_top #(.FRAME_DIV(DIV)) u_dut (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .ref_sample(ref_s),
		.mic_sample_0(mic_s[0]), .mic_sample_1(mic_s[1]), .mic_sample_2(mic_s[2]),
		.mic_sample_3(mic_s[3]), .speaker_out(spk), .adapt_enable(adapt),
		.out_valid(ovalid), .out_ready(ordy), .out_left(oleft), .out_right(oright)
	);
	armgdm_far_model u_far (
		.aclk(aclk), .aresetn(aresetn), .want_ref(want_ref), .want_mic(want_mic),
		.stall(stall), .ref_sample(ref_s), .mic_sample(mic_s), .out_ready(ordy)
	);

	// Clock of 4 ns period
	always #2 aclk = ~aclk;

	// ========================================================
	// Shared tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
			error_cnt++;
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		resp = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rdv = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		rd(a);
		chk(rdv, e);
		chk(32'(resp), 32'(RESP_OKAY));
	endtask
	task automatic pop();
		do @(posedge aclk); while (!(ovalid && ordy));
		fl = oleft;
		fr = oright;
	endtask
	task automatic skip(input int n);
		repeat (n) pop();
	endtask
	task automatic wait_adapt(input logic v);
		int n;
		n = 0;
		while (adapt !== v && n < 2000) begin
			@(posedge aclk);
			n++;
		end
		chk(32'(adapt), 32'(v));
	endtask

	// ========================================================
	// Scenarios
	task automatic t_regs();
		chk(32'(adapt), 32'h0);
		rdc(REG_REF_GAIN, 32'(GAIN_UNITY));
		rdc(REG_MIC_GAIN, 32'(GAIN_UNITY));
		rdc(REG_LEFT_SEL, 32'(LEFT_SEL_RESET));
		rdc(REG_RIGHT_SEL, 32'(RIGHT_SEL_RESET));
		rdc(REG_SILENCE, SILENCE_RESET);
		rdc(REG_DELAY, 32'(DELAY_RESET));
		rdc(REG_UPSAMPLE, 32'(UPSAMPLE_RESET));
		wr(REG_UPSAMPLE, 32'h0);
		rdc(REG_UPSAMPLE, 32'h0);
		wr(REG_UPSAMPLE, 32'h3);
		wr(8'h24, 32'h1);
		chk(32'(resp), 32'(RESP_SLVERR));
		rd(8'h24);
		chk(32'(resp), 32'(RESP_SLVERR));
	endtask
	task automatic t_adapt();
		want_ref <= 16'h4000;
		wait_adapt(1'b1);
		rd(REG_STATUS);
		chk(32'(rdv[0]), 32'h1);
		wr(REG_SILENCE, 32'hffffffff);
		wait_adapt(1'b0);
		wr(REG_SILENCE, SILENCE_RESET);
	endtask
	task automatic t_ref_gain();
		wr(REG_UPSAMPLE, 32'h2);
		want_ref <= 16'h1234;
		skip(12);
		chk(32'(fl), 32'h1234);
		chk(32'(fr), 32'h1234);
		wr(REG_REF_GAIN, 32'h2000);
		skip(12);
		chk(32'(fl), 32'h1234);
		chk(32'(fr), 32'h2468);
		chk(32'(spk), 32'h1234);
		want_ref <= 16'h7fff;
		skip(12);
		chk(32'(fr), 32'h7fff);
		chk(32'(spk), 32'h7fff);
		want_ref <= 16'ha000;
		skip(12);
		chk(32'(fr), 32'(SAT_NEG));
		wr(REG_REF_GAIN, 32'(GAIN_UNITY));
		wr(REG_UPSAMPLE, 32'(UPSAMPLE_RESET));
	endtask
	task automatic t_mic();
		wr(REG_MIC_GAIN, 32'h0800);
		want_mic <= {16'h0400, 16'h0300, 16'h0200, 16'h0100};
		for (int i = 0; i < 4; i++) begin
			wr(REG_LEFT_SEL, 32'(i * 256 + 3));
			wr(REG_RIGHT_SEL, 32'(i * 256 + 1));
			skip(12);
			chk(32'(fl), 32'(128 * (i + 1)));
			chk(32'(fr), 32'(256 * (i + 1)));
		end
		wr(REG_MIC_GAIN, 32'(GAIN_UNITY));
	endtask
	task automatic t_delay();
		int n;
		for (int c = 0; c < 5; c++) begin
			wr(REG_DELAY, 32'(DLY[c]));
			wr(REG_LEFT_SEL, 32'(LS[c]));
			wr(REG_RIGHT_SEL, 32'(RS[c]));
			wr(REG_UPSAMPLE, (c == 4) ? 32'h1 : 32'(UPSAMPLE_RESET));
			want_ref <= 16'h0111;
			want_mic <= {4{16'h0111}};
			skip(15);
			if (STEP[c]) want_ref <= 16'h0222;
			else want_mic <= {4{16'h0222}};
			do pop(); while (fr !== 16'h0222);
			n = 0;
			while (fl !== 16'h0222) begin
				n++;
				pop();
			end
			chk(32'(n), 32'(EXP_N[c]));
		end
		wr(REG_DELAY, 32'h0);
		wr(REG_UPSAMPLE, 32'(UPSAMPLE_RESET));
	endtask
	task automatic t_buffer();
		wr(REG_STATUS, 32'h2);
		rd(REG_STATUS);
		chk(32'(rdv[1]), 32'h0);
		stall <= 1'b1;
		repeat (5 * DIV) @(posedge aclk);
		chk(32'(ovalid), 32'h1);
		rd(REG_STATUS);
		chk(32'(rdv[1]), 32'h1);
		stall <= 1'b0;
		skip(2);
		wr(REG_STATUS, 32'h2);
		rd(REG_STATUS);
		chk(32'(rdv[1]), 32'h0);
	endtask

	// ========================================================
	// Verdict, sequence and watchdog
	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs();
		t_adapt();
		t_ref_gain();
		t_mic();
		t_delay();
		t_buffer();
		conclude();
	end
	initial begin
		#200000;
		error_cnt++;
		conclude();
	end
endmodule
